// >>> shared/oc_retry_pkg.sv
package oc_retry_pkg;

    // ****************************************
    // Timing
    // ****************************************
    // Clock period and delay time base, in picoseconds
    localparam int unsigned CLOCK_PERIOD_PS = 4000;
    localparam int unsigned TIME_UNIT_PS = 1000000000;
    localparam int unsigned MS_CYCLES = (TIME_UNIT_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int unsigned TIMER_W = 16;

    // ****************************************
    // Response byte layout and codes
    // ****************************************
    localparam int unsigned ACTION_LSB = 6;
    localparam int unsigned RETRY_LSB = 3;
    localparam int unsigned DELAY_LSB = 0;
    localparam logic [7:0] RESP_RESET = 8'hC0;
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_RETRY = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Delay unit field codes as a shift of the 1 ms base
    localparam logic [3:0] SHIFT_1MS = 4'h0;
    localparam logic [3:0] SHIFT_4MS = 4'h2;
    localparam logic [3:0] SHIFT_16MS = 4'h4;
    localparam logic [3:0] SHIFT_256MS = 4'h8;

    // Response byte fields, bit 7 first
    typedef struct packed {
        logic [1:0] action;
        logic [2:0] retries;
        logic [2:0] delay;
    } resp_t;

    typedef enum logic [2:0] {
        ST_STOPPED,
        ST_RUN,
        ST_LIMIT,
        ST_OFF_WAIT,
        ST_LATCHED
    } seq_state_t;

endpackage

// >>> src/overcurrent_fault_retry_sequencer.sv
module overcurrent_fault_retry_sequencer #(
    parameter int unsigned MS_CYCLES_P = oc_retry_pkg::MS_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fast_oc_pin,
    input wire logic [1:0] iout_delay_unit,
    input wire logic resp_wr,
    input wire logic [7:0] resp_wdata,
    input wire logic output_on,
    input wire logic bias_ok,
    input wire logic other_shutdown,
    input wire logic fault_clear,
    output logic [7:0] resp_rdata,
    output logic output_enable,
    output logic current_limit,
    output logic fault_status,
    output logic fault_notify,
    output logic restart_pulse,
    output logic latched_off,
    output logic [2:0] attempts
);

    localparam int PW = (MS_CYCLES_P > 1) ? $clog2(MS_CYCLES_P) : 1;
    localparam int TW = oc_retry_pkg::TIMER_W;

    if (MS_CYCLES_P < 2) begin : g_bad_ms
        $error("MS_CYCLES_P must be at least 2");
    end

    // ****************************************
    // Pin synchroniser and millisecond tick
    // ****************************************
    logic fault_meta;
    logic fault_sync;
    logic fault_prev;
    logic [PW-1:0] presc;
    logic [PW-1:0] next_presc;
    logic ms_tick;
    logic next_ms_tick;

    // Two flops before the comparator level is used
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
            fault_prev <= 1'b0;
        end else begin
            fault_meta <= fast_oc_pin;
            fault_sync <= fault_meta;
            fault_prev <= fault_sync;
        end
    end

    // Prescaler for the 1 ms base
    always_comb begin
        next_ms_tick = (presc == PW'(MS_CYCLES_P - 1));
        next_presc = next_ms_tick ? '0 : presc + PW'(1);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            presc <= '0;
            ms_tick <= 1'b0;
        end else begin
            presc <= next_presc;
            ms_tick <= next_ms_tick;
        end
    end

    // ****************************************
    // Response register and delay decode
    // ****************************************
    oc_retry_pkg::resp_t cfg;
    logic [7:0] next_resp;
    logic [3:0] unit_shift;
    logic [3:0] total_shift;
    logic [TW-1:0] delay_ms;

    assign cfg = oc_retry_pkg::resp_t'(resp_rdata);

    always_comb begin
        next_resp = resp_wr ? resp_wdata : resp_rdata;
        unique case (iout_delay_unit)
            2'h0: unit_shift = oc_retry_pkg::SHIFT_1MS;
            2'h1: unit_shift = oc_retry_pkg::SHIFT_4MS;
            2'h2: unit_shift = oc_retry_pkg::SHIFT_16MS;
            2'h3: unit_shift = oc_retry_pkg::SHIFT_256MS;
        endcase
        total_shift = 4'({1'b0, cfg.delay}) + unit_shift;
        delay_ms = TW'(1) << total_shift;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            resp_rdata <= oc_retry_pkg::RESP_RESET;
        end else begin
            resp_rdata <= next_resp;
        end
    end

    // ****************************************
    // Fault sequencer
    // ****************************************
    oc_retry_pkg::seq_state_t state;
    oc_retry_pkg::seq_state_t next_state;
    logic [TW-1:0] hold_cnt;
    logic [TW-1:0] next_hold_cnt;
    logic [TW-1:0] space_cnt;
    logic [TW-1:0] next_space_cnt;
    logic [2:0] next_attempts;
    logic next_enable;
    logic next_status;
    logic next_notify;
    logic next_restart;
    logic stop;
    logic used_up;

    always_comb begin
        // off, bias loss or other fault
        stop = !output_on || !bias_ok || other_shutdown;
        used_up = (cfg.retries != oc_retry_pkg::RETRY_FOREVER) && (attempts == cfg.retries);
        next_state = state;
        next_attempts = attempts;
        next_enable = output_enable;
        next_restart = 1'b0;
        next_hold_cnt = (ms_tick && hold_cnt != '0) ? hold_cnt - TW'(1) : hold_cnt;
        next_space_cnt = (ms_tick && space_cnt != '0) ? space_cnt - TW'(1) : space_cnt;
        next_notify = fault_sync && !fault_prev;
        next_status = next_notify || (fault_status && !fault_clear);
        unique case (state)
            oc_retry_pkg::ST_STOPPED: begin
                next_state = oc_retry_pkg::ST_RUN;
                next_enable = 1'b1;
            end
            oc_retry_pkg::ST_RUN: begin
                if (fault_sync && cfg.action != oc_retry_pkg::ACT_IGNORE) begin
                    next_state = oc_retry_pkg::ST_LIMIT;
                    next_hold_cnt = delay_ms;
                end
            end
            oc_retry_pkg::ST_LIMIT: begin
                if (!fault_sync) begin
                    next_state = oc_retry_pkg::ST_RUN;
                end else if (hold_cnt == '0) begin
                    next_enable = 1'b0;
                    if (used_up) begin
                        next_state = oc_retry_pkg::ST_LATCHED;
                    end else begin
                        next_state = oc_retry_pkg::ST_OFF_WAIT;
                        if (attempts == 3'h0) begin
                            next_space_cnt = delay_ms;
                        end
                    end
                end
            end
            oc_retry_pkg::ST_OFF_WAIT: begin
                if (space_cnt == '0) begin
                    next_state = oc_retry_pkg::ST_RUN;
                    next_enable = 1'b1;
                    next_restart = 1'b1;
                    next_space_cnt = delay_ms;
                    if (attempts != 3'h7) begin
                        next_attempts = attempts + 3'h1;
                    end
                end
            end
            oc_retry_pkg::ST_LATCHED: begin
                next_enable = 1'b0;
            end
        endcase
        // fresh sequence after clear or off
        if (stop) begin
            next_state = oc_retry_pkg::ST_STOPPED;
            next_enable = 1'b0;
            next_restart = 1'b0;
            next_attempts = 3'h0;
            next_hold_cnt = '0;
            next_space_cnt = '0;
        end else if (fault_clear) begin
            next_state = oc_retry_pkg::ST_RUN;
            next_enable = 1'b1;
            next_restart = 1'b0;
            next_attempts = 3'h0;
            next_hold_cnt = '0;
            next_space_cnt = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= oc_retry_pkg::ST_STOPPED;
            hold_cnt <= '0;
            space_cnt <= '0;
            attempts <= 3'h0;
            output_enable <= 1'b0;
            current_limit <= 1'b0;
            fault_status <= 1'b0;
            fault_notify <= 1'b0;
            restart_pulse <= 1'b0;
            latched_off <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            space_cnt <= next_space_cnt;
            attempts <= next_attempts;
            output_enable <= next_enable;
            current_limit <= next_enable && fault_sync;
            fault_status <= next_status;
            fault_notify <= next_notify;
            restart_pulse <= next_restart;
            latched_off <= (next_state == oc_retry_pkg::ST_LATCHED);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_off_when_stopped: assert property (stop |=> !output_enable && !restart_pulse)
        else $error("output on while stopped");
    a_zero_retry_latch: assert property (state == oc_retry_pkg::ST_LIMIT && hold_cnt == '0
        && fault_sync && cfg.retries == oc_retry_pkg::RETRY_NONE && !stop && !fault_clear
        |=> state == oc_retry_pkg::ST_LATCHED && latched_off)
        else $error("no latch with zero retries");
    a_latched_stays_off: assert property (state == oc_retry_pkg::ST_LATCHED && !stop
        && !fault_clear |=> !output_enable && state == oc_retry_pkg::ST_LATCHED)
        else $error("latched output came back");
    a_restart_counted: assert property (restart_pulse |-> attempts != 3'h0 && output_enable
        && $past(state) == oc_retry_pkg::ST_OFF_WAIT)
        else $error("restart without attempt count");
    a_limit_hold_load: assert property (state == oc_retry_pkg::ST_RUN && fault_sync
        && cfg.action == oc_retry_pkg::ACT_RETRY && !stop && !fault_clear
        |=> state == oc_retry_pkg::ST_LIMIT && hold_cnt == $past(delay_ms))
        else $error("hold timer not loaded");
    a_ignore_keeps_on: assert property (state == oc_retry_pkg::ST_RUN
        && cfg.action == oc_retry_pkg::ACT_IGNORE && !stop && !fault_clear
        |=> output_enable && state == oc_retry_pkg::ST_RUN)
        else $error("ignore response shut down");
    a_forever_retry: assert property (state == oc_retry_pkg::ST_LIMIT && hold_cnt == '0
        && fault_sync && cfg.retries == oc_retry_pkg::RETRY_FOREVER && !stop && !fault_clear
        |=> state == oc_retry_pkg::ST_OFF_WAIT)
        else $error("continuous retry stopped");
    a_space_restart: assert property (state == oc_retry_pkg::ST_OFF_WAIT && space_cnt == '0
        && !stop && !fault_clear |=> restart_pulse && space_cnt == $past(delay_ms))
        else $error("restart spacing wrong");
    a_notify_status: assert property (fault_sync && !fault_prev |=> fault_notify
        && fault_status)
        else $error("fault not reported");
    a_clear_fresh: assert property (fault_clear && !stop |=> attempts == 3'h0
        && hold_cnt == '0 && state == oc_retry_pkg::ST_RUN)
        else $error("clear did not reset sequence");

endmodule

// >>> test/pmbus_host_model.sv
// ****
// Host side of the response byte and clear strobes
// ****
module pmbus_host_model (
    input wire logic clock,
    input wire logic wr_req,
    input wire logic [7:0] wr_byte,
    input wire logic clr_req,
    output logic resp_wr,
    output logic [7:0] resp_wdata,
    output logic fault_clear
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        resp_wr = 1'b0;
        resp_wdata = 8'h00;
        fault_clear = 1'b0;
    end

    // One-cycle strobes; idle data bus alternates between the last byte and its inverse
    always @(posedge clock) begin
        resp_wr <= wr_req;
        fault_clear <= clr_req;
        resp_wdata <= wr_req ? wr_byte : ~resp_wdata;
    end
endmodule

// >>> test/test_overcurrent_fault_retry_sequencer.sv
// ****
// Bench for the overcurrent retry sequencer
// ****
module test_overcurrent_fault_retry_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 4;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic fast_oc_pin = 1'b0;
    logic [1:0] iout_delay_unit = 2'h0;
    logic output_on = 1'b1;
    logic bias_ok = 1'b1;
    logic other_shutdown = 1'b0;
    logic wr_req = 1'b0;
    logic [7:0] wr_byte = 8'h00;
    logic clr_req = 1'b0;
    logic resp_wr, fault_clear, output_enable, current_limit, fault_status;
    logic fault_notify, restart_pulse, latched_off;
    logic [7:0] resp_wdata, resp_rdata;
    logic [2:0] attempts;
    logic [31:0] seed = 32'h452B;
    int n_mismatch = 0;
    int checked = 0;

    always #2 clock = ~clock;

    pmbus_host_model u_host (.clock(clock), .wr_req(wr_req), .wr_byte(wr_byte),
        .clr_req(clr_req), .resp_wr(resp_wr), .resp_wdata(resp_wdata),
        .fault_clear(fault_clear));

    overcurrent_fault_retry_sequencer #(.MS_CYCLES_P(MS)) u_dut (.clock(clock), .rst_n(rst_n),
        .fast_oc_pin(fast_oc_pin), .iout_delay_unit(iout_delay_unit), .resp_wr(resp_wr),
        .resp_wdata(resp_wdata), .output_on(output_on), .bias_ok(bias_ok),
        .other_shutdown(other_shutdown), .fault_clear(fault_clear), .resp_rdata(resp_rdata),
        .output_enable(output_enable), .current_limit(current_limit),
        .fault_status(fault_status), .fault_notify(fault_notify),
        .restart_pulse(restart_pulse), .latched_off(latched_off), .attempts(attempts));

    // ****
    // Expectations and shared tasks
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Cycles in one delay step: 2^code units of 1, 4, 16 or 256 ms
    function automatic int step_cycles(input logic [2:0] dly, input logic [1:0] unit);
        int sh;
        sh = (unit == 2'h0) ? 0 : (unit == 2'h1) ? 2 : (unit == 2'h2) ? 4 : 8;
        return (1 << (int'(dly) + sh)) * MS;
    endfunction

    function automatic logic in_win(input int got, input int exp);
        return (got >= exp - MS) && (got <= exp + MS + 8);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic host_write(input logic [7:0] b);
        @(posedge clock) wr_req <= 1'b1;
        wr_byte <= b;
        @(posedge clock) wr_req <= 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic host_clear();
        @(posedge clock) clr_req <= 1'b1;
        @(posedge clock) clr_req <= 1'b0;
        repeat (4) @(negedge clock);
    endtask

    // Hold the fault and follow the whole shutdown and retry sequence
    task automatic run_retry(input logic [7:0] resp, input logic [1:0] unit);
        int pulses, last, fall, nn, st, lim;
        logic lat;
        pulses = 0;
        last = -1;
        fall = -1;
        nn = 0;
        lat = 1'b0;
        st = step_cycles(resp[2:0], unit);
        lim = 16 * st + 200;
        @(posedge clock) iout_delay_unit <= unit;
        host_write(resp);
        check(32'(resp_rdata), 32'(resp));
        @(posedge clock) fast_oc_pin <= 1'b1;
        // Continuous mode stops after six attempts, counted modes run to the latch
        for (int i = 0; i < lim && !lat && (pulses < 6 || resp[5:3] != 3'h7); i++) begin
            @(negedge clock);
            if (i == 5) check(32'(current_limit & fault_status), 32'h1);
            nn += int'(fault_notify === 1'b1);
            if (fall < 0 && output_enable === 1'b0) fall = i;
            if (restart_pulse === 1'b1) begin
                if (last >= 0) check(32'(in_win(i - last, st)), 32'h1);
                last = i;
                pulses++;
            end
            lat = (latched_off === 1'b1);
        end
        check(32'(in_win(fall, st + 4)), 32'h1);
        check(32'(nn), 32'h1);
        if (resp[5:3] == 3'h7) begin
            check(32'(lat), 32'h0);
            check(32'(pulses), 32'h6);
            if (pulses != 6) complete_run();
            @(posedge clock) bias_ok <= 1'b0;
            repeat (3) @(negedge clock);
            check(32'({output_enable, attempts}), 32'h0);
            @(posedge clock) bias_ok <= 1'b1;
        end else begin
            check(32'(pulses), 32'(resp[5:3]));
            check(32'({lat, output_enable, attempts}), 32'({2'b10, resp[5:3]}));
            if (!lat) complete_run();
        end
        @(posedge clock) fast_oc_pin <= 1'b0;
        host_clear();
        check(32'({latched_off, attempts, output_enable}), 32'h1);
        $display("test retry %h unit %0d done", resp, unit);
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        logic [2:0] rtab [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
        repeat (4) @(negedge clock);
        check(32'({resp_rdata, output_enable}), 32'h180);
        @(posedge clock) rst_n <= 1'b1;
        repeat (4) @(negedge clock);
        check(32'(output_enable), 32'h1);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            host_write(seed[7:0]);
            check(32'(resp_rdata), 32'(seed[7:0]));
        end
        $display("test register done");
        foreach (rtab[k]) begin
            seed = lfsr(seed);
            run_retry({2'h3, rtab[k], 1'b0, seed[0], ~seed[0]}, {1'b0, seed[1]});
        end
        run_retry(8'hC8, 2'h3);
        run_retry(8'hC7, 2'h0);
        // Ignore code: stays on in current limit
        host_write(8'h11);
        @(posedge clock) fast_oc_pin <= 1'b1;
        repeat (60) @(negedge clock);
        check(32'({output_enable, current_limit, latched_off}), 32'h6);
        // Another fault forces shutdown, then the output comes back
        @(posedge clock) other_shutdown <= 1'b1;
        repeat (3) @(negedge clock);
        check(32'({output_enable, attempts}), 32'h0);
        @(posedge clock) other_shutdown <= 1'b0;
        repeat (3) @(negedge clock);
        check(32'({output_enable, current_limit}), 32'h3);
        @(posedge clock) output_on <= 1'b0;
        repeat (3) @(negedge clock);
        check(32'(output_enable), 32'h0);
        $display("test ignore done");
        complete_run();
    end
endmodule
